// *** bench/ast_line_rx.sv ***
// behavioural remote receiver sampling the serial line
`timescale 1ns/10ps
module ast_line_rx (
    input wire logic clock,
    input wire logic txd,
    input wire logic [15:0] cellN,
    input wire logic [3:0] nBits,
    input wire logic parEn,
    output logic [7:0] rxData,
    output logic rxPar,
    output logic stopOk,
    output int frameN,
    output int rxCount
);
    longint lastT;
    int i;
    initial begin
        rxCount = 0;
        lastT = 0;
        forever begin
            @(negedge txd);
            // start to start spacing, in clocks
            frameN = int'(($time - lastT) / 100);
            lastT = $time;
            rxData = 8'h00;
            repeat ((cellN + 1) / 2) @(posedge clock);
            for (i = 0; i < nBits; i++) begin
                repeat (cellN) @(posedge clock);
                rxData[i] = txd;
            end
            if (parEn) begin
                repeat (cellN) @(posedge clock);
                rxPar = txd;
            end
            repeat (cellN) @(posedge clock);
            stopOk = txd;
            rxCount++;
        end
    end
endmodule // ast_line_rx

// *** bench/ast_transmitter_chk.sv ***
// port checker for the serial transmitter
`timescale 1ns/10ps
module ast_transmitter_chk
    import ast_pkg::*;
#(
    parameter int FIFO_DEPTH = 4
) (
    input wire logic clock,
    input wire logic rst_b,
    input wire ast_pkg::ast_apb_req_t apbReq,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic txd,
    input wire logic rtsN,
    input wire logic ctsN,
    input wire logic txIntReq,
    input wire logic txDmaReq
);
    // ****************************************
    // shadow copies of the written registers
    // ****************************************
    logic acc;
    logic rdAcc;
    logic [7:0] mode_q;
    logic [7:0] rxc_q;
    logic [7:0] txc_q;
    logic [7:0] fth_q;
    logic async_q;
    int brk_q;
    int cellN;
    assign acc = apbReq.psel & apbReq.penable;
    assign rdAcc = acc & !apbReq.pwrite;
    // baud divider is assumed left at zero by the bench
    assign cellN = (mode_q[7:6] == CLK_X1) ? 1 : (8 << mode_q[7:6]);
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            mode_q <= 8'h00;
            rxc_q <= 8'h00;
            txc_q <= 8'h00;
            fth_q <= 8'h00;
        end else if (acc && apbReq.pwrite) begin
            case (apbReq.paddr)
                ADDR_MODE: mode_q <= apbReq.pwdata[7:0];
                ADDR_RX_CTRL: rxc_q <= apbReq.pwdata[7:0];
                ADDR_TX_CTRL: txc_q <= apbReq.pwdata[7:0];
                ADDR_FIFO_TH: fth_q <= apbReq.pwdata[7:0];
                default: ;
            endcase
        end
    end
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            async_q <= 1'b0;
            brk_q <= 0;
        end else begin
            async_q <= async_q | (mode_q[3:2] != STOP_NONE);
            brk_q <= txc_q[TXC_BREAK] ? ((brk_q < 999) ? brk_q + 1 : brk_q) : 0;
        end
    end
    // ****************************************
    // assertions
    // ****************************************
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b);
    AST_SYNC_IDLE: assert property (!async_q && !txc_q[TXC_BREAK] |-> txd)
        else $error("line active in synchronous mode");
    AST_BREAK: assert property (brk_q > 2 * cellN |-> !txd)
        else $error("break not on line");
    AST_ALL_SENT: assert property (rdAcc && apbReq.paddr == ADDR_SPC_STAT && !$past(txd)
        |-> !prdata[SST_ALL_SENT])
        else $error("all sent while bits in flight");
    AST_RTS_PLAIN: assert property (!$past(rxc_q[RXC_AUTO_EN]) |-> rtsN == !$past(txc_q[TXC_RTS]))
        else $error("rts pin not inverse of bit");
    AST_RTS_AUTO: assert property ($past(rxc_q[RXC_AUTO_EN] & txc_q[TXC_RTS]) |-> !rtsN)
        else $error("auto rts not low");
    AST_RTS_HOLD: assert property (rxc_q[RXC_AUTO_EN] && !txd && !rtsN |=> !rtsN)
        else $error("auto rts released mid character");
    AST_CTS: assert property (rdAcc && apbReq.paddr == ADDR_PRI_STAT && $stable(ctsN)
        && ctsN == $past(ctsN, 2) && ctsN == $past(ctsN, 3) |-> prdata[PST_CTS] == !ctsN)
        else $error("cts status wrong");
    AST_INT_OFF: assert property (!fth_q[FTH_INT_EN] |-> !txIntReq)
        else $error("interrupt while disabled");
    AST_DMA_OFF: assert property (!fth_q[FTH_DMA_EN] |-> !txDmaReq)
        else $error("dma request while disabled");
    AST_INT_DMA: assert property (fth_q[FTH_INT_EN] && fth_q[FTH_DMA_EN] |-> txIntReq == txDmaReq)
        else $error("interrupt and dma disagree");
    AST_TBE_INT: assert property (rdAcc && apbReq.paddr == ADDR_PRI_STAT && fth_q[FTH_INT_EN]
        |-> prdata[PST_TBE] == txIntReq)
        else $error("buffer empty flag disagrees with request");
endmodule // ast_transmitter_chk

bind ast_transmitter ast_transmitter_chk #(.FIFO_DEPTH(FIFO_DEPTH)) u_ast_transmitter_chk (.clock(clock),
    .rst_b(rst_b), .apbReq(apbReq), .prdata(prdata), .pready(pready), .pslverr(pslverr), .txd(txd),
    .rtsN(rtsN), .ctsN(ctsN), .txIntReq(txIntReq), .txDmaReq(txDmaReq));

// *** bench/ast_transmitter_tb.sv ***
// self-checking bench for the serial transmitter
`timescale 1ns/10ps
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin failures++; \
    $display("BAD %s exp %h got %h", nm, e, g); end end
module ast_transmitter_tb;
    import ast_pkg::*;
    typedef struct {logic [7:0] mode; logic [7:0] txc; logic [7:0] data; int nb; logic [7:0] exp;} ast_row_t;
    logic clock = 1'b0;
    logic rst_b = 1'b0;
    ast_apb_req_t apbReq = '0;
    logic ctsN = 1'b0;
    logic [31:0] prdata;
    logic pready, pslverr, txd, rtsN, txIntReq, txDmaReq, err, rxPar, stopOk;
    logic [31:0] rd = 32'h0000_0000;
    logic [15:0] cellN = 16'h0001;
    logic [3:0] nBits = 4'h8;
    logic parEn = 1'b0;
    logic [7:0] rxData;
    int frameN, rxCount, n0;
    int failures = 0;
    int comparisons = 0;
    int cycles = 0;
    ast_row_t r;
    // mode byte: factor, stops, even, parity enable
    ast_row_t rows [9] = '{'{8'h04, 8'h68, 8'hA5, 8, 8'hA5}, '{8'h0F, 8'h28, 8'hD3, 7, 8'h53},
        '{8'h49, 8'h48, 8'hF6, 6, 8'h36}, '{8'h07, 8'h08, 8'hF1, 1, 8'h01}, '{8'h05, 8'h08, 8'hE2, 2, 8'h02},
        '{8'h0C, 8'h08, 8'hC5, 3, 8'h05}, '{8'h07, 8'h08, 8'h8A, 4, 8'h0A}, '{8'h8D, 8'h08, 8'h15, 5, 8'h15},
        '{8'hC4, 8'h68, 8'h3C, 8, 8'h3C}};
    ast_transmitter u_ast_transmitter (.clock(clock), .rst_b(rst_b), .apbReq(apbReq), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .txd(txd), .rtsN(rtsN), .ctsN(ctsN), .txIntReq(txIntReq),
        .txDmaReq(txDmaReq));
    ast_line_rx u_ast_line_rx (.clock(clock), .txd(txd), .cellN(cellN), .nBits(nBits), .parEn(parEn),
        .rxData(rxData), .rxPar(rxPar), .stopOk(stopOk), .frameN(frameN), .rxCount(rxCount));
    always #50 clock = ~clock;
    always @(posedge clock) begin
        cycles++;
        if (cycles == 60000) begin
            failures++;
            finish_test();
        end
    end
    // ****************************************
    // tasks
    // ****************************************
    task automatic finish_test();
        $display("checks %0d mismatches %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // entered just after a rising edge; ends two edges after release
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        apbReq.psel <= 1'b1;
        apbReq.pwrite <= w;
        apbReq.paddr <= a;
        apbReq.pwdata <= d;
        @(posedge clock);
        apbReq.penable <= 1'b1;
        do begin
            @(posedge clock);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        apbReq.psel <= 1'b0;
        apbReq.penable <= 1'b0;
        @(posedge clock);
        @(posedge clock);
    endtask
    task automatic wait_rx(input int n);
        int k;
        k = 0;
        while (rxCount < n && k < 3000) begin
            @(posedge clock);
            k++;
        end
        `CHK("rxCount", n, rxCount)
    endtask
    task automatic wait_sent();
        int k;
        k = 0;
        rd = 32'h0000_0000;
        while (rd[SST_ALL_SENT] !== 1'b1 && k < 400) begin
            apb(0, ADDR_SPC_STAT, 0);
            k++;
        end
        `CHK("allSent", 1'b1, rd[SST_ALL_SENT])
        `CHK("idle txd", 1'b1, txd)
    endtask
    task automatic do_reset();
        rst_b <= 1'b0;
        repeat (3) @(posedge clock);
        rst_b <= 1'b1;
        @(posedge clock);
        `CHK("reset txd", 1'b1, txd)
        `CHK("reset rtsN", 1'b1, rtsN)
        apb(0, ADDR_PRI_STAT, 0);
        `CHK("reset empty", 1'b1, rd[PST_TBE])
    endtask
    // ****************************************
    // sequence
    // ****************************************
    initial begin
        do_reset();
        apb(0, 8'h20, 0);
        `CHK("unmapped err", 1'b1, err)
        `CHK("unmapped rd", 32'h0000_0000, rd)
        // stop code zero: a written character must stay put
        n0 = rxCount;
        apb(1, ADDR_TX_DATA, 32'h0000_0055);
        apb(1, ADDR_TX_CTRL, 32'h0000_0068);
        repeat (40) @(posedge clock);
        `CHK("sync rx", n0, rxCount)
        do_reset();
        // mode first, enable last; no one-and-half stops at x1
        foreach (rows[i]) begin
            r = rows[i];
            cellN = (r.mode[7:6] == 2'b00) ? 16'h0001 : 16'(8 << r.mode[7:6]);
            nBits = 4'(r.nb);
            parEn = r.mode[0];
            n0 = rxCount;
            apb(1, ADDR_TX_CTRL, 0);
            apb(1, ADDR_MODE, {24'h0, r.mode});
            apb(1, ADDR_TX_DATA, {24'h0, r.data});
            apb(1, ADDR_TX_DATA, {24'h0, r.data});
            apb(1, ADDR_TX_CTRL, {24'h0, r.txc});
            wait_rx(n0 + 2);
            `CHK("data", r.exp, rxData)
            if (parEn) `CHK("parity", r.mode[1] ? ^r.exp : ~^r.exp, rxPar)
            `CHK("stop", 1'b1, stopOk)
            `CHK("frame", int'(cellN) * (1 + r.nb + r.mode[0]) + int'(cellN) * (int'(r.mode[3:2]) + 1) / 2,
                frameN)
            wait_sent();
        end
        // break sent while idle, between characters
        apb(1, ADDR_MODE, 32'h0000_0004);
        apb(1, ADDR_TX_CTRL, 32'h0000_0078);
        cellN = 16'h0001;
        `CHK("break on", 1'b0, txd)
        apb(1, ADDR_TX_CTRL, 32'h0000_0068);
        `CHK("break off", 1'b1, txd)
        repeat (20) @(posedge clock);
        apb(1, ADDR_TX_CTRL, 32'h0000_006A);
        `CHK("rts set", 1'b0, rtsN)
        apb(1, ADDR_TX_CTRL, 32'h0000_0068);
        `CHK("rts clr", 1'b1, rtsN)
        apb(1, ADDR_RX_CTRL, 32'h0000_0020);
        apb(1, ADDR_MODE, 32'h0000_0044);
        cellN = 16'h0010;
        nBits = 4'h8;
        parEn = 1'b0;
        apb(1, ADDR_TX_CTRL, 32'h0000_006A);
        `CHK("auto rts", 1'b0, rtsN)
        apb(1, ADDR_TX_DATA, 32'h0000_0081);
        apb(1, ADDR_TX_CTRL, 32'h0000_0068);
        `CHK("auto hold", 1'b0, rtsN)
        wait_sent();
        repeat (2) @(posedge clock);
        `CHK("auto drop", 1'b1, rtsN)
        // clear-to-send gates new characters
        apb(1, ADDR_MODE, 32'h0000_0004);
        cellN = 16'h0001;
        ctsN <= 1'b1;
        n0 = rxCount;
        apb(1, ADDR_TX_DATA, 32'h0000_003C);
        repeat (30) @(posedge clock);
        `CHK("cts held", n0, rxCount)
        apb(0, ADDR_PRI_STAT, 0);
        `CHK("cts bit", 1'b0, rd[PST_CTS])
        ctsN <= 1'b0;
        wait_rx(n0 + 1);
        `CHK("cts data", 8'h3C, rxData)
        apb(0, ADDR_PRI_STAT, 0);
        `CHK("cts bit", 1'b1, rd[PST_CTS])
        // buffer filled until refused, thresholds, drain
        wait_sent();
        apb(1, ADDR_TX_CTRL, 32'h0000_0060);
        apb(1, ADDR_FIFO_TH, 32'h0000_0003);
        `CHK("int empty", 1'b1, txIntReq)
        `CHK("dma empty", 1'b1, txDmaReq)
        n0 = rxCount;
        repeat (4) apb(1, ADDR_TX_DATA, 32'h0000_0077);
        `CHK("int full", 1'b0, txIntReq)
        apb(1, ADDR_TX_DATA, 32'h0000_0077);
        `CHK("full err", 1'b1, err)
        apb(0, ADDR_PRI_STAT, 0);
        `CHK("tbe full", 1'b0, rd[PST_TBE])
        apb(1, ADDR_FIFO_TH, 32'h0000_0023);
        apb(1, ADDR_TX_CTRL, 32'h0000_0068);
        wait_rx(n0 + 4);
        wait_sent();
        `CHK("int drained", 1'b1, txIntReq)
        apb(1, ADDR_TX_CTRL, 32'h0000_0060);
        apb(1, ADDR_TX_DATA, 32'h0000_0011);
        `CHK("int one left", 1'b0, txIntReq)
        apb(0, ADDR_PRI_STAT, 0);
        `CHK("tbe one left", 1'b0, rd[PST_TBE])
        apb(1, ADDR_FIFO_TH, 32'h0000_0003);
        `CHK("int room", 1'b1, txIntReq)
        apb(1, ADDR_FIFO_TH, 32'h0000_0000);
        `CHK("int off", 1'b0, txIntReq)
        finish_test();
    end
endmodule // ast_transmitter_tb

// *** logic/ast_pkg.sv ***
// package of constants and carrier types for the asynchronous serial transmitter
package ast_pkg;
    // ****************************************
    // register offsets (byte addresses)
    // ****************************************
    localparam logic [7:0] ADDR_MODE = 8'h00;
    localparam logic [7:0] ADDR_RX_CTRL = 8'h04;
    localparam logic [7:0] ADDR_TX_CTRL = 8'h08;
    localparam logic [7:0] ADDR_FIFO_TH = 8'h0C;
    localparam logic [7:0] ADDR_TX_DATA = 8'h10;
    localparam logic [7:0] ADDR_PRI_STAT = 8'h14;
    localparam logic [7:0] ADDR_SPC_STAT = 8'h18;
    localparam logic [7:0] ADDR_BAUD_DIV = 8'h1C;
    // ****************************************
    // field positions
    // ****************************************
    localparam int MODE_PAR_EN = 0;
    localparam int MODE_PAR_EVEN = 1;
    localparam int MODE_STOP_LO = 2;
    localparam int MODE_CLK_LO = 6;
    localparam int RXC_AUTO_EN = 5;
    localparam int TXC_RTS = 1;
    localparam int TXC_TX_EN = 3;
    localparam int TXC_BREAK = 4;
    localparam int TXC_LEN_LO = 5;
    localparam int FTH_INT_EN = 0;
    localparam int FTH_DMA_EN = 1;
    localparam int FTH_ALL_EMPTY = 5;
    localparam int PST_TBE = 2;
    localparam int PST_CTS = 5;
    localparam int SST_ALL_SENT = 0;
    // ****************************************
    // reset values and encodings
    // ****************************************
    localparam logic [7:0] RST_REG8 = 8'h00;
    localparam logic [15:0] RST_BAUD_DIV = 16'h0000;
    localparam logic [1:0] STOP_NONE = 2'h0;
    localparam logic [1:0] STOP_ONE = 2'h1;
    localparam logic [1:0] STOP_ONE_HALF = 2'h2;
    localparam logic [1:0] CLK_X1 = 2'h0;
    localparam logic [1:0] CLK_X16 = 2'h1;
    localparam logic [1:0] CLK_X32 = 2'h2;
    localparam logic [1:0] LEN_FIVE = 2'h0;
    localparam logic [1:0] LEN_SEVEN = 2'h1;
    localparam logic [1:0] LEN_SIX = 2'h2;
    localparam logic [7:0] TICKS_X1 = 8'h01;
    localparam logic [7:0] TICKS_X16 = 8'h10;
    localparam logic [7:0] TICKS_X32 = 8'h20;
    localparam logic [7:0] TICKS_X64 = 8'h40;
    localparam int FIFO_DEPTH_DEF = 4;

    typedef enum logic [2:0] {
        AST_IDLE = 3'b000,
        AST_START = 3'b001,
        AST_DATA = 3'b011,
        AST_PARITY = 3'b010,
        AST_STOP = 3'b110
    } ast_state_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } ast_apb_req_t;

    typedef struct packed {
        logic prdata_unused;
        logic pready;
        logic pslverr;
    } ast_apb_flags_t;
endpackage

// *** logic/ast_transmitter.sv ***
// asynchronous serial transmitter with apb register slave and transmit buffer
//
// Notes on behaviour
// [RULE1] stop bits choose one, one-half, two
// [RULE2] non-zero stop code selects asynchronous mode
// [RULE3] stop and clock factor encodings fixed
// [RULE4] length bits choose five, seven, six, eight
// [RULE5] unused upper data bits are ignored
// [RULE6] five-bit mode decodes leading-ones length marker
// [RULE7] optional parity bit, even or odd
// [RULE8] break drives zeros from next cell boundary
// [RULE9] software starts break only between characters
// [RULE10] all-sent only after last stop bit
// [RULE11] clock factor one, sixteen, thirty-two, sixty-four
// [RULE12] zero clock factor means times-one mode
// [RULE13] no one-and-half stops in times-one mode
// [RULE14] rts pin inverts rts bit normally
// [RULE15] auto rts holds low until all sent
// [RULE16] cts status; auto enables gate transmitter
// [RULE17] software programs mode first, enables last
// [RULE18] buffer to shifter, start, parity, shift out
// [RULE19] single buffer requests whenever buffer empty
// [RULE20] fifo threshold selects entry-empty or all-empty
// [RULE21] buffer-empty status follows the threshold choice
//
// The implementer's own choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/10ps
module ast_transmitter #(
    parameter int FIFO_DEPTH = ast_pkg::FIFO_DEPTH_DEF
) (
    input wire logic clock,
    input wire logic rst_b,
    input wire ast_pkg::ast_apb_req_t apbReq,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic txd,
    output logic rtsN,
    input wire logic ctsN,
    output logic txIntReq,
    output logic txDmaReq
);
    import ast_pkg::*;

    localparam int PW = (FIFO_DEPTH > 1) ? $clog2(FIFO_DEPTH) : 1;
    localparam int CW = $clog2(FIFO_DEPTH + 1);

    if (FIFO_DEPTH < 1 || FIFO_DEPTH > 16 || (FIFO_DEPTH & (FIFO_DEPTH - 1)) != 0) begin : g_depth_check
        $error("FIFO_DEPTH must be a power of two from 1 to 16");
    end

    // ****************************************
    // register file
    // ****************************************
    logic [7:0] modeReg_q;
    logic [7:0] rxCtrlReg_q;
    logic [7:0] txCtrlReg_q;
    logic [7:0] fifoThReg_q;
    logic [15:0] baudDiv_q;
    logic wrAcc;
    logic rdAcc;
    logic mapped;
    logic dataPush;
    logic fifoFull;
    logic bufEmptyFlag;
    logic allSent_q;
    logic [CW-1:0] fifoCount_q;

    assign wrAcc = apbReq.psel & apbReq.penable & apbReq.pwrite;
    assign rdAcc = apbReq.psel & apbReq.penable & ~apbReq.pwrite;
    // slave never waits: every access completes in its first access cycle
    assign pready = 1'b1;

    always_comb begin
        unique case (apbReq.paddr)
            ADDR_MODE, ADDR_RX_CTRL, ADDR_TX_CTRL, ADDR_FIFO_TH,
            ADDR_TX_DATA, ADDR_PRI_STAT, ADDR_SPC_STAT, ADDR_BAUD_DIV: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end

    // a write to a full buffer is refused so no character is overwritten
    assign dataPush = wrAcc & (apbReq.paddr == ADDR_TX_DATA) & ~fifoFull;
    assign pslverr = apbReq.psel & apbReq.penable &
                     (~mapped | (apbReq.pwrite & (apbReq.paddr == ADDR_TX_DATA) & fifoFull));

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            modeReg_q <= RST_REG8;
            rxCtrlReg_q <= RST_REG8;
            txCtrlReg_q <= RST_REG8;
            fifoThReg_q <= RST_REG8;
            baudDiv_q <= RST_BAUD_DIV;
        end else if (wrAcc) begin
            unique case (apbReq.paddr)
                ADDR_MODE: modeReg_q <= apbReq.pwdata[7:0];
                ADDR_RX_CTRL: rxCtrlReg_q <= apbReq.pwdata[7:0];
                ADDR_TX_CTRL: txCtrlReg_q <= apbReq.pwdata[7:0];
                ADDR_FIFO_TH: fifoThReg_q <= apbReq.pwdata[7:0];
                ADDR_BAUD_DIV: baudDiv_q <= apbReq.pwdata[15:0];
                default: ;
            endcase
        end
    end

    logic [31:0] rdData_d;
    always_comb begin
        rdData_d = 32'h0000_0000;
        unique case (apbReq.paddr)
            ADDR_MODE: rdData_d[7:0] = modeReg_q;
            ADDR_RX_CTRL: rdData_d[7:0] = rxCtrlReg_q;
            ADDR_TX_CTRL: rdData_d[7:0] = txCtrlReg_q;
            ADDR_FIFO_TH: rdData_d[7:0] = fifoThReg_q;
            ADDR_PRI_STAT: begin
                rdData_d[PST_TBE] = bufEmptyFlag; // [RULE19] [RULE21]
                rdData_d[PST_CTS] = ~ctsN; // [RULE16]
            end
            ADDR_SPC_STAT: rdData_d[SST_ALL_SENT] = allSent_q; // [RULE10]
            ADDR_BAUD_DIV: rdData_d[15:0] = baudDiv_q;
            default: ;
        endcase
    end

    // read data is combinational off the registers since pready is immediate
    assign prdata = rdAcc ? rdData_d : 32'h0000_0000;

    // ****************************************
    // mode decode
    // ****************************************
    logic [1:0] stopSel;
    logic [1:0] clkSel;
    logic [1:0] lenSel;
    logic asyncMode;
    logic autoEn;
    logic [7:0] factorTicks;
    logic [7:0] stopTicks;

    assign stopSel = modeReg_q[MODE_STOP_LO +: 2];
    assign clkSel = modeReg_q[MODE_CLK_LO +: 2];
    assign lenSel = txCtrlReg_q[TXC_LEN_LO +: 2];
    assign asyncMode = (stopSel != STOP_NONE); // [RULE2]
    assign autoEn = rxCtrlReg_q[RXC_AUTO_EN];

    always_comb begin
        unique case (clkSel) // [RULE3] [RULE11]
            CLK_X1: factorTicks = TICKS_X1; // [RULE12]
            CLK_X16: factorTicks = TICKS_X16;
            CLK_X32: factorTicks = TICKS_X32;
            default: factorTicks = TICKS_X64;
        endcase
        // times-one with one-and-half stops rounds to one tick; software must avoid it
        unique case (stopSel) // [RULE1] [RULE3] [RULE13]
            STOP_ONE: stopTicks = factorTicks;
            STOP_ONE_HALF: stopTicks = factorTicks + {1'b0, factorTicks[7:1]};
            default: stopTicks = {factorTicks[6:0], 1'b0};
        endcase
    end

    // ****************************************
    // transmit buffer
    // ****************************************
    logic [7:0] fifoMem [FIFO_DEPTH];
    logic [PW-1:0] wrPtr_q;
    logic [PW-1:0] rdPtr_q;
    logic fifoPop;
    logic fifoEmpty;

    assign fifoEmpty = (fifoCount_q == '0);
    assign fifoFull = (fifoCount_q == CW'(FIFO_DEPTH));
    // deep buffer: threshold picks entry-slot-free or fully drained
    assign bufEmptyFlag = (FIFO_DEPTH > 1 && !fifoThReg_q[FTH_ALL_EMPTY]) ? ~fifoFull : fifoEmpty; // [RULE20]
    assign txIntReq = fifoThReg_q[FTH_INT_EN] & bufEmptyFlag; // [RULE19] [RULE20]
    assign txDmaReq = fifoThReg_q[FTH_DMA_EN] & bufEmptyFlag; // [RULE19] [RULE20]

    always_ff @(posedge clock) begin
        if (dataPush) begin
            fifoMem[wrPtr_q] <= apbReq.pwdata[7:0];
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            wrPtr_q <= '0;
            rdPtr_q <= '0;
            fifoCount_q <= '0;
        end else begin
            if (dataPush) begin
                wrPtr_q <= (wrPtr_q == PW'(FIFO_DEPTH - 1)) ? '0 : wrPtr_q + 1'b1;
            end
            if (fifoPop) begin
                rdPtr_q <= (rdPtr_q == PW'(FIFO_DEPTH - 1)) ? '0 : rdPtr_q + 1'b1;
            end
            if (dataPush && !fifoPop) begin
                fifoCount_q <= fifoCount_q + 1'b1;
            end else if (fifoPop && !dataPush) begin
                fifoCount_q <= fifoCount_q - 1'b1;
            end
        end
    end

    // ****************************************
    // bit-cell timing
    // ****************************************
    logic [15:0] divCnt_q;
    logic [7:0] cellCnt_q;
    logic [7:0] cellLen;
    logic baudTick;
    logic cellEnd;
    ast_state_t state_q;

    assign baudTick = (divCnt_q == baudDiv_q);
    assign cellLen = (state_q == AST_STOP) ? stopTicks : factorTicks;
    assign cellEnd = baudTick & (cellCnt_q >= cellLen - 8'h01);

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            divCnt_q <= 16'h0000;
        end else begin
            divCnt_q <= baudTick ? 16'h0000 : divCnt_q + 16'h0001;
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            cellCnt_q <= 8'h00;
        end else if (cellEnd) begin
            cellCnt_q <= 8'h00;
        end else if (baudTick) begin
            cellCnt_q <= cellCnt_q + 8'h01;
        end
    end

    // ****************************************
    // character decode
    // ****************************************
    logic [7:0] head;
    logic [3:0] nBits;
    logic [7:0] charData;

    assign head = fifoMem[rdPtr_q];

    always_comb begin
        unique case (lenSel) // [RULE4]
            LEN_FIVE: begin
                // leading ones mark how short the character is
                if (!head[7]) begin // [RULE6]
                    nBits = 4'd5;
                end else if (!head[6]) begin
                    nBits = 4'd4;
                end else if (!head[5]) begin
                    nBits = 4'd3;
                end else if (!head[4]) begin
                    nBits = 4'd2;
                end else begin
                    nBits = 4'd1;
                end
            end
            LEN_SEVEN: nBits = 4'd7;
            LEN_SIX: nBits = 4'd6;
            default: nBits = 4'd8;
        endcase
        charData = head & ~(8'hFF << nBits); // [RULE5] [RULE6]
    end

    // ****************************************
    // shifter and line
    // ****************************************
    logic [7:0] shift_q;
    logic [3:0] bitsLeft_q;
    logic parity_q;
    logic txd_q;
    logic canStart;
    logic ctsOk;

    assign ctsOk = ~autoEn | ~ctsN; // [RULE16]
    assign canStart = asyncMode & txCtrlReg_q[TXC_TX_EN] & ctsOk & ~fifoEmpty;
    assign fifoPop = cellEnd & canStart & ((state_q == AST_IDLE) | (state_q == AST_STOP)); // [RULE18]

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            state_q <= AST_IDLE;
            shift_q <= 8'h00;
            bitsLeft_q <= 4'h0;
            parity_q <= 1'b0;
        end else if (cellEnd) begin
            unique case (state_q) // [RULE18]
                AST_IDLE, AST_STOP: begin
                    if (canStart) begin
                        state_q <= AST_START;
                        shift_q <= charData;
                        bitsLeft_q <= nBits;
                        parity_q <= modeReg_q[MODE_PAR_EVEN] ? ^charData : ~^charData; // [RULE7]
                    end else begin
                        state_q <= AST_IDLE;
                    end
                end
                AST_START, AST_DATA: begin
                    if (bitsLeft_q != 4'h0) begin
                        state_q <= AST_DATA;
                        shift_q <= {1'b0, shift_q[7:1]};
                        bitsLeft_q <= bitsLeft_q - 4'h1;
                    end else begin
                        state_q <= modeReg_q[MODE_PAR_EN] ? AST_PARITY : AST_STOP; // [RULE7]
                    end
                end
                AST_PARITY: state_q <= AST_STOP;
                default: state_q <= AST_IDLE;
            endcase
        end
    end

    logic lineBit;
    always_comb begin
        unique case (state_q)
            AST_IDLE, AST_STOP: lineBit = canStart ? 1'b0 : 1'b1;
            AST_START, AST_DATA: lineBit = (bitsLeft_q != 4'h0) ? shift_q[0] : (parity_q | ~modeReg_q[MODE_PAR_EN]);
            AST_PARITY: lineBit = 1'b1;
            default: lineBit = 1'b1;
        endcase
    end

    // line only changes on cell boundaries, so break starts and stops there too
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            txd_q <= 1'b1;
        end else if (cellEnd) begin
            txd_q <= txCtrlReg_q[TXC_BREAK] ? 1'b0 : lineBit; // [RULE8]
        end
    end
    assign txd = txd_q;

    // ****************************************
    // all sent and modem output
    // ****************************************
    logic rtsHold_q;
    logic rtsN_q;

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            allSent_q <= 1'b1;
        end else begin
            allSent_q <= (state_q == AST_IDLE) & fifoEmpty; // [RULE10]
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            rtsHold_q <= 1'b0;
        end else if (txCtrlReg_q[TXC_RTS]) begin
            rtsHold_q <= 1'b1; // [RULE15]
        end else if (allSent_q) begin
            rtsHold_q <= 1'b0; // [RULE15]
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            rtsN_q <= 1'b1;
        end else begin
            rtsN_q <= autoEn ? ~(txCtrlReg_q[TXC_RTS] | rtsHold_q) : ~txCtrlReg_q[TXC_RTS]; // [RULE14] [RULE15]
        end
    end
    assign rtsN = rtsN_q;

endmodule // ast_transmitter
